// file: design/stc_top.v
// Notes on behaviour
// - Words are searched level by level, each level naming the next; trigger on completion.
// - An event counter holds a level until its word occurred enough times.
// - A level may restrict detection to a window of sample counts.
// - OR-combined words are compared in parallel; any match satisfies.
// - Present branch fires its action once, on the detection that completes the count.
// - Absent branch fires its action when the word fails to appear for the whole period.
// - Absent search is bounded by a programmed period, judged at its end.
// - Absent branch returns to level zero when its word appears; when fulfilled it triggers or goes to its target.
// - Time channels are stored with the data on the same sample; same address.
// - The master clock may switch between data and time domain clocks.
// - Any external clock may be assigned master in turn.
// - Sync mode stores one sample per master edge, at successive addresses.
// - Transition mode stores a word whenever a data input changes, else none.
// - Transition mode still stores the time channels beside each word and stores until memory is full.
// - Qualification mode: each level decides which samples get stored.
// - A restart returns the sequencer immediately to level zero.
// - Window counts samples from level entry; hits outside it are ignored, no hit by its end returns to level zero.
// - Each level matches at most two words at once.
// - After trigger, recording continues for the delay count, then stops.
`include "stc_consts.vh"

module stc_top #(
   parameter DW    = 32,
   parameter TW    = 8,
   parameter NCLK  = 4,
   parameter NLEV  = 8,
   parameter LW    = 3,
   parameter DEPTH = 2048,
   parameter AW    = 11
)(
   // Clock and reset.
   input  wire          aclk,
   input  wire          aresetn,
   // AXI4-Lite write address and data.
   input  wire [11:0]   s_axi_awaddr,
   input  wire          s_axi_awvalid,
   output reg           s_axi_awready,
   input  wire [31:0]   s_axi_wdata,
   input  wire [3:0]    s_axi_wstrb,
   input  wire          s_axi_wvalid,
   output reg           s_axi_wready,
   // AXI4-Lite write response.
   output reg  [1:0]    s_axi_bresp,
   output reg           s_axi_bvalid,
   input  wire          s_axi_bready,
   // AXI4-Lite read.
   input  wire [11:0]   s_axi_araddr,
   input  wire          s_axi_arvalid,
   output reg           s_axi_arready,
   output reg  [31:0]   s_axi_rdata,
   output reg  [1:0]    s_axi_rresp,
   output reg           s_axi_rvalid,
   input  wire          s_axi_rready,
   // Probe pins.
   input  wire [DW-1:0] probe_data,
   input  wire [TW-1:0] time_chan,
   input  wire [NCLK-1:0] ext_clk,
   // Status pins.
   output reg           recording_r,
   output reg           triggered_r
);

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function [31:0] stc_merge;
      input [31:0] old;
      input [31:0] dat;
      input [3:0]  strb;
      integer k;
      begin
         for (k = 0; k < 4; k = k + 1) begin
            stc_merge[k*8 +: 8] = strb[k] ? dat[k*8 +: 8] : old[k*8 +: 8];
         end
      end
   endfunction

   function is_lvl;
      input [11:0] a;
      begin
         is_lvl = (a[11:8] == `STC_OFF_LVL >> 8) &&
                  ({{(32-LW){1'b0}}, a[LW+4:5]} < NLEV) &&
                  (a[4:2] <= `STC_LVL_WIN);
      end
   endfunction

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   reg [DW-1:0]   dat_s1_r, dat_s2_r, dat_prev_r;
   reg [TW-1:0]   tim_s1_r, tim_s2_r;
   reg [NCLK-1:0] clk_s1_r, clk_s2_r, clk_s3_r;

   always @(posedge aclk) begin
      if (!aresetn) begin
         dat_s1_r   <= {DW{1'b0}};
         dat_s2_r   <= {DW{1'b0}};
         dat_prev_r <= {DW{1'b0}};
         tim_s1_r   <= {TW{1'b0}};
         tim_s2_r   <= {TW{1'b0}};
         clk_s1_r   <= {NCLK{1'b0}};
         clk_s2_r   <= {NCLK{1'b0}};
         clk_s3_r   <= {NCLK{1'b0}};
      end else begin
         dat_s1_r   <= probe_data;
         dat_s2_r   <= dat_s1_r;
         dat_prev_r <= dat_s2_r;
         tim_s1_r   <= time_chan;
         tim_s2_r   <= tim_s1_r;
         clk_s1_r   <= ext_clk;
         clk_s2_r   <= clk_s1_r;
         clk_s3_r   <= clk_s2_r;
      end
   end

   // ****************************************************************
   // Configuration storage
   // ****************************************************************
   reg [3:0]  msel_r;
   reg        qual_en_r, trans_r;
   reg [31:0] delay_r;
   reg [AW-1:0] midx_r;
   reg [DW-1:0] lw0_r [0:NLEV-1];
   reg [DW-1:0] lm0_r [0:NLEV-1];
   reg [DW-1:0] lw1_r [0:NLEV-1];
   reg [DW-1:0] lm1_r [0:NLEV-1];
   reg [31:0]   lctl_r [0:NLEV-1];
   reg [31:0]   lwin_r [0:NLEV-1];

   // ****************************************************************
   // AXI4-Lite handshake
   // ****************************************************************
   reg        aw_full_r, w_full_r;
   reg [11:0] awaddr_r;
   reg [31:0] wdata_r;
   reg [3:0]  wstrb_r;
   wire aw_take = s_axi_awvalid & s_axi_awready;
   wire w_take  = s_axi_wvalid & s_axi_wready;
   wire wr_en   = aw_full_r & w_full_r & ~s_axi_bvalid;
   wire ar_take = s_axi_arvalid & s_axi_arready;
   wire wr_lvl  = wr_en & is_lvl(awaddr_r);
   wire [LW-1:0] wr_li = awaddr_r[LW+4:5];
   wire wr_ctrl = wr_en & (awaddr_r == `STC_OFF_CTRL);
   wire wr_ok   = is_lvl(awaddr_r) | wr_ctrl |
                  (awaddr_r == `STC_OFF_DELAY) |
                  (awaddr_r == `STC_OFF_MIDX);

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_r     <= 1'b0;
         w_full_r      <= 1'b0;
         awaddr_r      <= 12'h000;
         wdata_r       <= 32'h00000000;
         wstrb_r       <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `STC_RESP_OKAY;
      end else begin
         if (aw_take) begin
            awaddr_r <= s_axi_awaddr;
         end
         if (w_take) begin
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         aw_full_r     <= (aw_full_r | aw_take) & ~wr_en;
         w_full_r      <= (w_full_r | w_take) & ~wr_en;
         s_axi_awready <= ~((aw_full_r | aw_take) & ~wr_en);
         s_axi_wready  <= ~((w_full_r | w_take) & ~wr_en);
         if (wr_en) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? `STC_RESP_OKAY : `STC_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Level registers, one writer block per level.
   genvar g;
   generate
      for (g = 0; g < NLEV; g = g + 1) begin : g_lvl
         always @(posedge aclk) begin
            if (!aresetn) begin
               lw0_r[g]  <= {DW{1'b0}};
               lm0_r[g]  <= {DW{1'b1}};
               lw1_r[g]  <= {DW{1'b0}};
               lm1_r[g]  <= {DW{1'b1}};
               lctl_r[g] <= 32'h00000000;
               lwin_r[g] <= 32'h00000000;
            end else if (wr_lvl && wr_li == g) begin
               case (awaddr_r[4:2])
                  `STC_LVL_W0:  lw0_r[g]  <= wdata_r[DW-1:0];
                  `STC_LVL_M0:  lm0_r[g]  <= wdata_r[DW-1:0];
                  `STC_LVL_W1:  lw1_r[g]  <= wdata_r[DW-1:0];
                  `STC_LVL_M1:  lm1_r[g]  <= wdata_r[DW-1:0];
                  `STC_LVL_CTL: lctl_r[g] <=
                     stc_merge(lctl_r[g], wdata_r, wstrb_r);
                  `STC_LVL_WIN: lwin_r[g] <=
                     stc_merge(lwin_r[g], wdata_r, wstrb_r);
                  default: lctl_r[g] <= lctl_r[g];
               endcase
            end
         end
      end
   endgenerate

   always @(posedge aclk) begin
      if (!aresetn) begin
         msel_r    <= `STC_MSEL_RST;
         qual_en_r <= 1'b0;
         trans_r   <= 1'b0;
         delay_r   <= `STC_DELAY_RST;
         midx_r    <= {AW{1'b0}};
      end else if (wr_en) begin
         if (wr_ctrl && wstrb_r[0]) begin
            msel_r    <= wdata_r[`STC_CTRL_MSEL +: 4];
            qual_en_r <= wdata_r[`STC_CTRL_QUAL];
            trans_r   <= wdata_r[`STC_CTRL_TRANS];
         end
         if (awaddr_r == `STC_OFF_DELAY) begin
            delay_r <= stc_merge(delay_r, wdata_r, wstrb_r);
         end
         if (awaddr_r == `STC_OFF_MIDX) begin
            midx_r <= wdata_r[AW-1:0];
         end
      end
   end

   // ****************************************************************
   // Sample event selection
   // ****************************************************************
   // Index NCLK or above selects the internal clock: every aclk cycle.
   reg mclk_ev;
   integer i;
   always @* begin
      mclk_ev = 1'b1;
      for (i = 0; i < NCLK; i = i + 1) begin
         if (msel_r == i) begin
            mclk_ev = clk_s2_r[i] & ~clk_s3_r[i];
         end
      end
   end

   wire trans_ev = |(dat_s2_r ^ dat_prev_r);
   wire samp_ev  = trans_r ? trans_ev : mclk_ev;

   // ****************************************************************
   // Trigger sequencer
   // ****************************************************************
   reg [LW-1:0] level_r;
   reg [15:0]   ev_cnt_r, smp_cnt_r;
   reg          done_r, full_r;
   reg [31:0]   dly_cnt_r;
   reg [AW-1:0] wptr_r, taddr_r;

   wire [31:0] cc = lctl_r[level_r];
   wire [15:0] lo = lwin_r[level_r][15:0];
   wire [15:0] hi = lwin_r[level_r][31:16];
   wire [15:0] tgt_cnt = cc[`STC_LC_CNT +: 16];
   wire        c_abs  = cc[`STC_LC_ABSENT];
   wire        c_win  = cc[`STC_LC_WIN];
   wire        c_trig = cc[`STC_LC_TRIG];
   wire [LW-1:0] c_tgt = cc[`STC_LC_TGT +: LW];
   wire hit0, hit1, hit_any;

   stc_word_match #(.DW(DW)) u_match (
      .sample (dat_s2_r),
      .word0  (lw0_r[level_r]),
      .mask0  (lm0_r[level_r]),
      .word1  (lw1_r[level_r]),
      .mask1  (lm1_r[level_r]),
      .or_en  (cc[`STC_LC_OR]),
      .hit0   (hit0),
      .hit1   (hit1),
      .hit    (hit_any)
   );

   wire in_win  = ~c_win | (smp_cnt_r >= lo && smp_cnt_r <= hi);
   wire hit     = hit_any & in_win;
   // An absent search ends at the programmed period unless its word appears first.
   wire win_end = (c_win | c_abs) && (smp_cnt_r >= hi);
   wire cnt_ok  = ({16'h0000, ev_cnt_r} + 32'h00000001) >=
                  {16'h0000, tgt_cnt};

   reg [1:0] qmode;
   reg       qual_ok;
   always @* begin
      qmode = cc[`STC_LC_QUAL +: 2];
      case (qmode)
         2'h0:    qual_ok = 1'b1;
         2'h1:    qual_ok = hit0;
         2'h2:    qual_ok = hit1;
         default: qual_ok = 1'b0;
      endcase
      if (!qual_en_r || triggered_r) begin
         qual_ok = 1'b1;
      end
   end

   wire seq_ev = recording_r & ~triggered_r & samp_ev;
   wire store  = recording_r & samp_ev & qual_ok &
                 ~(trans_r & full_r) &
                 ~(triggered_r & (dly_cnt_r == 32'h00000000));
   wire start  = wr_ctrl & wstrb_r[0] & wdata_r[`STC_CTRL_RUN];
   wire halt   = wr_ctrl & wstrb_r[0] & ~wdata_r[`STC_CTRL_RUN];

   // Memory words hold the time channels beside the data channels, so
   // the trigger sits at one address for both groups.
   reg [DW+TW-1:0] mem_r [0:DEPTH-1];

   always @(posedge aclk) begin
      if (store) begin
         mem_r[wptr_r] <= {tim_s2_r, dat_s2_r};
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         recording_r <= 1'b0;
         triggered_r <= 1'b0;
         done_r      <= 1'b0;
         full_r      <= 1'b0;
         level_r     <= {LW{1'b0}};
         ev_cnt_r    <= 16'h0000;
         smp_cnt_r   <= 16'h0000;
         dly_cnt_r   <= 32'h00000000;
         wptr_r      <= {AW{1'b0}};
         taddr_r     <= {AW{1'b0}};
      end else if (start) begin
         recording_r <= 1'b1;
         triggered_r <= 1'b0;
         done_r      <= 1'b0;
         full_r      <= 1'b0;
         level_r     <= {LW{1'b0}};
         ev_cnt_r    <= 16'h0000;
         smp_cnt_r   <= 16'h0000;
         wptr_r      <= {AW{1'b0}};
      end else if (halt) begin
         recording_r <= 1'b0;
      end else begin
         if (store) begin
            wptr_r <= wptr_r + 1'b1;
            if (wptr_r == DEPTH - 1) begin
               full_r <= 1'b1;
            end
            if (trans_r && wptr_r == DEPTH - 1) begin
               recording_r <= 1'b0;
               done_r      <= 1'b1;
            end
            if (triggered_r) begin
               dly_cnt_r <= dly_cnt_r - 32'h00000001;
            end
         end
         if (recording_r && triggered_r && dly_cnt_r == 32'h00000000) begin
            recording_r <= 1'b0;
            done_r      <= 1'b1;
         end
         if (seq_ev) begin
            if (smp_cnt_r != 16'hFFFF) begin
               smp_cnt_r <= smp_cnt_r + 16'h0001;
            end
            if (!c_abs && hit && !cnt_ok) begin
               ev_cnt_r <= ev_cnt_r + 16'h0001;
            end else if ((!c_abs && hit) || (c_abs && !hit && win_end)) begin
               // Action of a fulfilled present or absent branch.
               if (c_trig) begin
                  triggered_r <= 1'b1;
                  taddr_r     <= wptr_r;
                  dly_cnt_r   <= delay_r;
               end else begin
                  level_r   <= c_tgt;
                  ev_cnt_r  <= 16'h0000;
                  smp_cnt_r <= 16'h0000;
               end
            end else if ((c_abs && hit) || (c_win && win_end)) begin
               level_r   <= {LW{1'b0}};
               ev_cnt_r  <= 16'h0000;
               smp_cnt_r <= 16'h0000;
            end
         end
      end
   end

   // ****************************************************************
   // Register read
   // ****************************************************************
   reg [31:0] rd_data;
   reg        rd_err;
   reg [DW+TW-1:0] mword;
   always @* begin
      rd_data = 32'h00000000;
      rd_err  = 1'b0;
      mword   = mem_r[midx_r];
      if (is_lvl(s_axi_araddr)) begin
         case (s_axi_araddr[4:2])
            `STC_LVL_W0:  rd_data[DW-1:0] = lw0_r[s_axi_araddr[LW+4:5]];
            `STC_LVL_M0:  rd_data[DW-1:0] = lm0_r[s_axi_araddr[LW+4:5]];
            `STC_LVL_W1:  rd_data[DW-1:0] = lw1_r[s_axi_araddr[LW+4:5]];
            `STC_LVL_M1:  rd_data[DW-1:0] = lm1_r[s_axi_araddr[LW+4:5]];
            `STC_LVL_CTL: rd_data = lctl_r[s_axi_araddr[LW+4:5]];
            default:      rd_data = lwin_r[s_axi_araddr[LW+4:5]];
         endcase
      end else begin
         case (s_axi_araddr)
            `STC_OFF_CTRL: begin
               rd_data[`STC_CTRL_RUN]    = recording_r;
               rd_data[`STC_CTRL_QUAL]   = qual_en_r;
               rd_data[`STC_CTRL_TRANS]  = trans_r;
               rd_data[`STC_CTRL_MSEL +: 4] = msel_r;
            end
            `STC_OFF_STATUS: begin
               rd_data[3:0] = {full_r, done_r, triggered_r, recording_r};
               rd_data[`STC_ST_LVL +: LW] = level_r;
               rd_data[`STC_ST_EVC +: 16] = ev_cnt_r;
            end
            `STC_OFF_DELAY: rd_data = delay_r;
            `STC_OFF_MIDX:  rd_data[AW-1:0] = midx_r;
            `STC_OFF_MDATA: rd_data[DW-1:0] = mword[DW-1:0];
            `STC_OFF_TADDR: rd_data[AW-1:0] = taddr_r;
            `STC_OFF_WPTR:  rd_data[AW-1:0] = wptr_r;
            `STC_OFF_MTIME: rd_data[TW-1:0] = mword[DW+TW-1:DW];
            default:        rd_err = 1'b1;
         endcase
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `STC_RESP_OKAY;
      end else if (ar_take) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_data;
         s_axi_rresp   <= rd_err ? `STC_RESP_SLVERR : `STC_RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end

endmodule // stc_top

// file: design/stc_consts.vh
`ifndef STC_CONSTS_VH
`define STC_CONSTS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define STC_OFF_CTRL    12'h000
`define STC_OFF_STATUS  12'h004
`define STC_OFF_DELAY   12'h008
`define STC_OFF_MIDX    12'h00C
`define STC_OFF_MDATA   12'h010
`define STC_OFF_TADDR   12'h014
`define STC_OFF_WPTR    12'h018
`define STC_OFF_MTIME   12'h01C
`define STC_OFF_LVL     12'h100
`define STC_LVL_W0      3'h0
`define STC_LVL_M0      3'h1
`define STC_LVL_W1      3'h2
`define STC_LVL_M1      3'h3
`define STC_LVL_CTL     3'h4
`define STC_LVL_WIN     3'h5

// ****************************************************************
// Field positions
// ****************************************************************
`define STC_CTRL_RUN    0
`define STC_CTRL_QUAL   1
`define STC_CTRL_TRANS  2
`define STC_CTRL_MSEL   4
`define STC_LC_OR       0
`define STC_LC_ABSENT   1
`define STC_LC_TRIG     2
`define STC_LC_TGT      4
`define STC_LC_WIN      8
`define STC_LC_QUAL     10
`define STC_LC_CNT      16
`define STC_ST_LVL      4
`define STC_ST_EVC      16

// ****************************************************************
// Reset values and bus answers
// ****************************************************************
`define STC_DELAY_RST   32'h00000700
`define STC_MSEL_RST    4'h0
`define STC_RESP_OKAY   2'h0
`define STC_RESP_SLVERR 2'h2

`endif

// file: design/stc_word_match.v
// ****************************************************************
// Two-word comparator with don't-care masks
// ****************************************************************
module stc_word_match #(
   parameter DW = 32
)(
   // Sample and programmed words.
   input  wire [DW-1:0] sample,
   input  wire [DW-1:0] word0,
   input  wire [DW-1:0] mask0,
   input  wire [DW-1:0] word1,
   input  wire [DW-1:0] mask1,
   // OR combination enable.
   input  wire          or_en,
   // Results.
   output wire          hit0,
   output wire          hit1,
   output wire          hit
);

   // A set mask bit means the sample bit is ignored.
   assign hit0 = &(~(sample ^ word0) | mask0);
   assign hit1 = &(~(sample ^ word1) | mask1);
   assign hit  = hit0 | (or_en & hit1);

endmodule // stc_word_match

// file: tb/stc_props.sv
module stc_props (
   // Clock and reset.
   input wire        aclk,
   input wire        aresetn,
   // Bus handshakes.
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   // Status pins.
   input wire        recording_r,
   input wire        triggered_r
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // ****************************************
   // Bus steps
   // ****************************************
   sequence aw_take; s_axi_awvalid && s_axi_awready; endsequence
   sequence w_take; s_axi_wvalid && s_axi_wready; endsequence
   sequence wr_done; s_axi_bvalid && s_axi_bready; endsequence
   sequence rd_done; s_axi_rvalid && s_axi_rready; endsequence

   wr_answer_a: assert property (aw_take and w_take |=> ##1 s_axi_bvalid)
      else $error("write answer late");
   aw_block_a: assert property (aw_take |=> !s_axi_awready)
      else $error("address taken while one is held");
   wr_release_a: assert property (wr_done |=> !s_axi_bvalid
      ##[0:1] s_axi_awready) else $error("write channel not freed");
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid) else $error("read answer late");
   ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   rd_release_a: assert property (rd_done |=> !s_axi_rvalid
      ##[0:1] s_axi_arready) else $error("read channel not freed");

   // ****************************************
   // Trigger and run status
   // ****************************************
   trig_in_run_a: assert property ($rose(triggered_r) |-> recording_r)
      else $error("trigger outside a recording");
   trig_hold_a: assert property (triggered_r
      |=> triggered_r || $rose(recording_r)) else $error("trigger lost");
   reset_quiet_a: assert property ($rose(aresetn)
      |-> !recording_r && !triggered_r && !s_axi_awready)
      else $error("outputs active after reset");
endmodule // stc_props

bind stc_top stc_props u_stc_props (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .recording_r(recording_r),
   .triggered_r(triggered_r)
);

// file: tb/stc_probe_model.sv
module stc_probe_model (
   // Target pins.
   output logic [31:0] probe_data,
   output logic [7:0]  time_chan,
   output logic [3:0]  ext_clk
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      probe_data = 32'h0;
      time_chan  = 8'h00;
      ext_clk    = 4'h0;
   end

   // Time channels come from an oscillator unrelated to the bus clock.
   always #70 time_chan = time_chan + 8'h01;

   // The target clock stands still between words, so one rising edge per word.
   task send(input [31:0] w, input int c);
      #13 probe_data = w;
      #160 ext_clk[c] = 1'b1;
      #160 ext_clk[c] = 1'b0;
      #160;
   endtask

   task chg(input [31:0] w);
      #13 probe_data = w;
      #200;
   endtask
endmodule // stc_probe_model

// file: tb/stc_top_tb_top.sv
module stc_top_tb_top;
   timeunit 1ns;
   timeprecision 1ns;

   logic        aclk    = 1'b0;
   logic        aresetn = 1'b0;
   logic [11:0] awaddr  = 12'h000;
   logic [11:0] araddr  = 12'h000;
   logic [31:0] wdata   = 32'h0;
   logic        awvalid = 1'b0;
   logic        wvalid  = 1'b0;
   logic        bready  = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready  = 1'b0;
   logic [31:0] d;
   logic [1:0]  r;
   wire         awready, wready, bvalid, arready, rvalid, rec, trig;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata, probe;
   wire  [7:0]  tchan;
   wire  [3:0]  eclk;
   int          n_fail = 0;
   int          checks = 0;
   localparam [31:0] wa = 32'h0000A5A5;
   localparam [31:0] wb = 32'h00003C3C;
   localparam [31:0] wc = 32'h000000C3;
   localparam [31:0] wd = 32'h00001111;

   always #20 aclk = ~aclk;

   stc_top #(.DEPTH(16), .AW(4)) u_stc_top (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .probe_data(probe), .time_chan(tchan), .ext_clk(eclk),
      .recording_r(rec), .triggered_r(trig)
   );
   stc_probe_model u_stc_probe_model (
      .probe_data(probe), .time_chan(tchan), .ext_clk(eclk)
   );

   // ****************************************
   // Bus and probe tasks
   // ****************************************
   task chk(input [31:0] g, input [31:0] e);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask

   task wr(input [11:0] a, input [31:0] v, input [1:0] e = 2'h0);
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= v;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk(bresp, e);
   endtask

   task rd(input [11:0] a);
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      d = rdata;
      r = rresp;
   endtask

   task rc(input [11:0] a, input [31:0] e);
      rd(a);
      chk(d, e);
   endtask

   task stat(input [31:0] m, input [31:0] e);
      rd(12'h004);
      chk(d & m, e);
   endtask

   task lv(input [11:0] b, input [31:0] w, m, c, win);
      wr(b, w);
      wr(b + 12'h004, m);
      wr(b + 12'h010, c);
      wr(b + 12'h014, win);
   endtask

   task go(input [31:0] c);
      wr(12'h000, 32'h0);
      wr(12'h000, c);
   endtask

   task sd(input [31:0] w, input int c = 0);
      u_stc_probe_model.send(w, c);
   endtask

   task test_done;
      if (n_fail == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task t_regs;
      rc(12'h008, 32'h00000700);
      rc(12'h104, 32'hFFFFFFFF);
      rc(12'h000, 32'h0);
      rc(12'h0FC, 32'h0);
      chk(r, 2'h2);
      wr(12'h0FC, 32'h1, 2'h2);
   endtask

   task t_seq;
      wr(12'h008, 32'h3);
      lv(12'h100, wa, 32'hFF000000, 32'h10, 32'h0);
      lv(12'h120, wb, 32'h0, 32'h4, 32'h0);
      go(32'h1);
      sd(wb);
      chk(trig, 1'b0);
      sd(wa | 32'h5A000000);
      stat(32'h70, 32'h10);
      sd(wb);
      chk(trig, 1'b1);
      sd(wd);
      sd(wd);
      chk(rec, 1'b1);
      sd(wd);
      chk(rec, 1'b0);
      rc(12'h018, 32'h6);
   endtask

   task t_count;
      lv(12'h100, wa, 32'h0, 32'h00030010, 32'h0);
      go(32'h1);
      sd(wa);
      sd(wa);
      sd(wb);
      stat(32'hFFFF0070, 32'h00020000);
      sd(wa);
      sd(wb);
      chk(trig, 1'b1);
   endtask

   task t_or;
      lv(12'h100, wa, 32'h0, 32'h5, 32'h0);
      wr(12'h108, wc);
      wr(12'h10C, 32'h0);
      go(32'h1);
      sd(wd);
      chk(trig, 1'b0);
      sd(wc);
      chk(trig, 1'b1);
   endtask

   task t_absent;
      lv(12'h100, wa, 32'h0, 32'h12, 32'h00020000);
      go(32'h1);
      repeat (4) sd(wa);
      sd(wd);
      sd(wd);
      stat(32'h70, 32'h0);
      sd(wd);
      stat(32'h70, 32'h10);
      sd(wb);
      chk(trig, 1'b1);
   endtask

   task t_window;
      lv(12'h100, wa, 32'h0, 32'h104, 32'h00040002);
      go(32'h1);
      sd(wa);
      sd(wa);
      sd(wd);
      chk(trig, 1'b0);
      sd(wa);
      chk(trig, 1'b1);
   endtask

   task t_clock;
      lv(12'h100, wa, 32'h0, 32'h4, 32'h0);
      go(32'h11);
      sd(wa, 0);
      chk(trig, 1'b0);
      sd(wa, 1);
      chk(trig, 1'b1);
      u_stc_probe_model.chg(wd);
      go(32'h41);
      chk(trig, 1'b0);
      u_stc_probe_model.chg(wa);
      chk(trig, 1'b1);
   endtask

   task t_qual;
      lv(12'h100, wa, 32'h0, 32'h400, 32'h0);
      go(32'h3);
      sd(wd);
      sd(wa);
      sd(wd);
      rc(12'h018, 32'h1);
   endtask

   task t_trans;
      lv(12'h100, wb, 32'h0, 32'h4, 32'h0);
      go(32'h5);
      for (int i = 1; i <= 3; i++) u_stc_probe_model.chg(32'h100 + i);
      repeat (20) @(posedge aclk);
      rc(12'h018, 32'h3);
      for (int i = 4; i <= 17; i++) u_stc_probe_model.chg(32'h100 + i);
      stat(32'h9, 32'h8);
   endtask

   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs;
      t_seq;
      t_count;
      t_or;
      t_absent;
      t_window;
      t_clock;
      t_qual;
      t_trans;
      test_done;
   end

   // Whole run needs about 35 us; this leaves ample margin.
   initial begin
      #400000;
      n_fail++;
      test_done;
   end
endmodule // stc_top_tb_top
